// ### src/phy_control_register.sv
`timescale 1ns/1ps
// How it works
// - 16-bit read/write control register at address 0
// - Reset loads 0x3100
// - Bit 8 selects full or half duplex
// - Duplex writable by software and autonegotiation
// - Bit 7 enters collision-test operation
// - Collision test set on transmit, cleared on halt
// - Write value comes from transmit-data register
// - Read result held in receive-data register
module phy_control_register import phy_ctrl_pkg::*; (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Management transaction port
  input wire logic mgmt_start_i,            // One-cycle transaction request
  input wire logic mgmt_write_i,            // 1 write, 0 read
  input wire logic [4:0] mgmt_addr_i,       // Register address
  input wire logic [15:0] mgmt_write_value_i, // From transmit-data register
  output logic [15:0] mgmt_read_value_o,    // Into receive-data register
  output logic mgmt_done_o,                 // One-cycle completion pulse
  // Autonegotiation result
  input wire logic an_complete_i,           // Pulse: negotiation finished
  input wire logic an_duplex_i,             // Negotiated duplex
  // Transmit activity for collision test
  input wire logic tx_start_i,              // Pulse: transmission initiated
  input wire logic tx_halt_i,               // Pulse: transmission halted
  // Control outputs to the physical layer
  output logic phy_reset_o,
  output logic loopback_select_o,
  output logic speed_choice_o,
  output logic autoneg_enable_o,
  output logic low_power_select_o,
  output logic isolate_o,
  output logic autoneg_restart_o,
  output logic duplex_o,
  output logic collision_test_select_o
);
  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [15:0] phy_control;       // The control register itself
  logic [15:0] next_phy_control;
  logic [15:0] rd_value;          // Holds the last read result
  logic [15:0] next_rd_value;
  logic done;                     // Completion pulse
  logic next_done;
  logic rst_busy;                 // Soft reset sequence active
  logic rst_done;                 // Soft reset sequence complete
  logic an_busy;                  // Restart in progress
  logic next_an_busy;
  logic hit;                      // Transaction addresses this register

  // Decode of the management address
  // Only one register lives here; every other address is a hole
  function automatic logic addr_hit(input logic [4:0] a);
    addr_hit = (a == PHY_CONTROL_ADDR);
  endfunction

  // Soft reset hold sequence
  phy_reset_seq #(.CYCLES(SOFT_RESET_CYCLES)) u_reset_seq (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .start_i(phy_control[BIT_SOFT_RESET]),
    .busy_o(rst_busy),
    .done_o(rst_done)
  );

  // Address match, qualified later by start and direction
  assign hit = addr_hit(mgmt_addr_i);

  // ------------------------------------------------------------
  // Next-value logic
  // ------------------------------------------------------------
  // Priority: software write first, then hardware events on top, so a
  // hardware set is never lost behind the write in the same cycle.
  always_comb begin
    next_phy_control = phy_control;
    next_rd_value = rd_value;
    next_done = 1'b0;
    next_an_busy = an_busy;
    // Management transaction: every request completes, mapped or not
    if (mgmt_start_i) begin
      next_done = 1'b1;
      // Software write takes the whole word at once
      if (mgmt_write_i && hit) begin
        next_phy_control = mgmt_write_value_i;
        // Reserved bits kept zero whatever software writes
        next_phy_control[RSVD_HI:RSVD_LO] = RSVD_RESET;
      end else if (!mgmt_write_i) begin
        // Unmapped addresses read as zero
        next_rd_value = hit ? phy_control : 16'h0000;
      end
    end
    // Negotiated duplex overrides the stored value
    if (an_complete_i && phy_control[BIT_AN_EN]) begin
      next_phy_control[BIT_DUPLEX] = an_duplex_i;
      next_an_busy = 1'b0;
    end
    // Restart accepted: hold busy until negotiation completes
    if (phy_control[BIT_AN_RESTART] && !an_busy) begin
      next_an_busy = 1'b1;
    end
    // Restart done: drop the bit and free the tracker, even with
    // negotiation disabled, so a later restart is not stuck busy
    if (an_busy && an_complete_i) begin
      next_phy_control[BIT_AN_RESTART] = 1'b0;
      next_an_busy = 1'b0;
    end
    // Collision test follows transmit activity; start wins over halt
    if (tx_halt_i) begin
      next_phy_control[BIT_COLTEST] = 1'b0;
    end
    if (tx_start_i) begin
      next_phy_control[BIT_COLTEST] = 1'b1;
    end
    // Soft reset completion returns the control register to defaults and frees the restart tracker; the held read value stays
    if (rst_done) begin
      next_phy_control = PHY_CONTROL_RESET;
      next_an_busy = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      phy_control <= PHY_CONTROL_RESET;
      rd_value <= 16'h0000;
      done <= 1'b0;
      an_busy <= 1'b0;
    end else begin
      phy_control <= next_phy_control;
      rd_value <= next_rd_value;
      done <= next_done;
      an_busy <= next_an_busy;
    end
  end

  // ------------------------------------------------------------
  // Output flops
  // ------------------------------------------------------------
  // Pins copy the stored state one cycle later, so done, the held read
  // value and the control levels all appear together two edges after
  // the request; the extra cycle buys pins that leave a flop directly.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      phy_reset_o <= 1'b0;
      loopback_select_o <= 1'b0;
      speed_choice_o <= 1'b1;
      autoneg_enable_o <= 1'b1;
      low_power_select_o <= 1'b0;
      isolate_o <= 1'b0;
      autoneg_restart_o <= 1'b0;
      duplex_o <= 1'b1;
      collision_test_select_o <= 1'b0;
      mgmt_read_value_o <= 16'h0000;
      mgmt_done_o <= 1'b0;
    end else begin
      phy_reset_o <= phy_control[BIT_SOFT_RESET];
      loopback_select_o <= phy_control[BIT_LOOPBACK];
      speed_choice_o <= phy_control[BIT_SPEED];
      autoneg_enable_o <= phy_control[BIT_AN_EN];
      low_power_select_o <= phy_control[BIT_LOW_POWER];
      isolate_o <= phy_control[BIT_ISOLATE];
      autoneg_restart_o <= phy_control[BIT_AN_RESTART];
      duplex_o <= phy_control[BIT_DUPLEX];
      collision_test_select_o <= phy_control[BIT_COLTEST];
      mgmt_read_value_o <= rd_value;
      mgmt_done_o <= done;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_reset_default: assert property (@(posedge sys_clk_i)
    !rstn_i |=> phy_control == PHY_CONTROL_RESET)
    else $error("control not at default after reset");
  a_write_stores: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    mgmt_start_i && mgmt_write_i && hit && !tx_start_i && !tx_halt_i && !an_complete_i
    && !rst_done |=> phy_control[15:10] == $past(mgmt_write_value_i[15:10]))
    else $error("write value not stored");
  a_rsvd_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    phy_control[RSVD_HI:RSVD_LO] == RSVD_RESET)
    else $error("reserved bits nonzero");
  a_read_holds: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    mgmt_start_i && !mgmt_write_i && hit |=> ##1 mgmt_read_value_o == $past(phy_control, 2))
    else $error("read value wrong");
  a_coltest_set: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    tx_start_i && !rst_done |=> ##1 collision_test_select_o)
    else $error("collision test not set on transmit");
  a_coltest_clr: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    tx_halt_i && !tx_start_i && !(mgmt_start_i && mgmt_write_i && hit) |=> ##1
    !collision_test_select_o)
    else $error("collision test not cleared on halt");
  a_duplex_an: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    an_complete_i && phy_control[BIT_AN_EN] && !rst_done |=> phy_control[BIT_DUPLEX] ==
    $past(an_duplex_i))
    else $error("negotiated duplex not taken");
  a_softrst_clear: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(phy_control[BIT_SOFT_RESET]) |-> ##[1:8] !phy_control[BIT_SOFT_RESET])
    else $error("soft reset bit did not self-clear");
  a_done_pulse: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    mgmt_start_i |=> ##1 mgmt_done_o)
    else $error("transaction not completed");
  // The hold sequence must not re-arm on its own done pulse, or a write
  // made after the soft reset would be wiped a second time
  a_softrst_once: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    rst_done |=> !rst_busy)
    else $error("soft reset sequence restarted");
  // Restart bit drops once the negotiation it started has finished
  a_restart_clear: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    an_busy && an_complete_i |=> !phy_control[BIT_AN_RESTART])
    else $error("restart bit not cleared on completion");
  // Speed, negotiation enable and duplex pins follow the stored bits
  a_mirror_out: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    {speed_choice_o, autoneg_enable_o, duplex_o} ==
    {$past(phy_control[BIT_SPEED]), $past(phy_control[BIT_AN_EN]),
    $past(phy_control[BIT_DUPLEX])})
    else $error("control pins do not follow register");
endmodule

// ### src/phy_ctrl_pkg.sv
package phy_ctrl_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [4:0] PHY_CONTROL_ADDR = 5'h00;  // Management address of the register
  localparam int unsigned REG_W = 16;               // Register width
  localparam logic [15:0] PHY_CONTROL_RESET = 16'h3100;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned BIT_SOFT_RESET = 15;
  localparam int unsigned BIT_LOOPBACK = 14;
  localparam int unsigned BIT_SPEED = 13;
  localparam int unsigned BIT_AN_EN = 12;
  localparam int unsigned BIT_LOW_POWER = 11;
  localparam int unsigned BIT_ISOLATE = 10;
  localparam int unsigned BIT_AN_RESTART = 9;
  localparam int unsigned BIT_DUPLEX = 8;
  localparam int unsigned BIT_COLTEST = 7;
  localparam int unsigned RSVD_HI = 6;
  localparam int unsigned RSVD_LO = 0;
  localparam logic [6:0] RSVD_RESET = 7'h00;
  // ------------------------------------------------------------
  // Timing: cycles the internal reset pulse is held
  // ------------------------------------------------------------
  localparam int unsigned SOFT_RESET_CYCLES = 4;
endpackage

// ### src/phy_reset_seq.sv
`timescale 1ns/1ps
// Counts a fixed number of cycles after a start pulse, then pulses done
module phy_reset_seq import phy_ctrl_pkg::*; #(
  parameter int unsigned CYCLES = SOFT_RESET_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Control
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  // The counter is eight bits wide, so longer holds cannot be served
  if (CYCLES < 1 || CYCLES > 255) begin : g_cycles_bad
    $error("CYCLES out of range");
  end
  logic [7:0] count;       // Remaining cycles
  logic [7:0] next_count;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;
  // Next-state computation
  always_comb begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    // Start is a level, so the done cycle must not re-arm the count
    // while the caller has not yet cleared its request
    if (start_i && !busy && !done) begin
      next_busy = 1'b1;
      next_count = 8'(CYCLES);
    end else if (busy) begin
      if (count == 8'h01) begin
        // Last cycle of the sequence
        next_busy = 1'b0;
        next_done = 1'b1;
        next_count = 8'h00;
      end else begin
        next_count = count - 8'h01;
      end
    end
  end
  // State registers
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      count <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end
  assign busy_o = busy;
  assign done_o = done;
endmodule

// ### testbench/mgmt_master_model.sv
`timescale 1ns/1ps
// ----
// Management master: one transaction at a time
// ----
module mgmt_master_model (
  // Clock
  input wire logic sys_clk_i,
  // Request side
  output logic mgmt_start_o,
  output logic mgmt_write_o,
  output logic [4:0] mgmt_addr_o,
  output logic [15:0] mgmt_write_value_o,
  // Answer side
  input wire logic mgmt_done_i,
  input wire logic [15:0] mgmt_read_value_i
);
  logic [15:0] rd_data; // Last captured read result
  logic ok; // Last transfer saw its done pulse
  // Idle bus at time zero
  initial begin
    mgmt_start_o = 1'b0;
    mgmt_write_o = 1'b0;
    mgmt_addr_o = 5'h00;
    mgmt_write_value_o = 16'hA5A5;
  end
  // Qualifiers held until done, then scrambled so stale data never looks valid
  task automatic xfer(input logic wr, input logic [4:0] adr, input logic [15:0] val);
    int n;
    n = 0;
    ok = 1'b0;
    @(negedge sys_clk_i);
    mgmt_start_o = 1'b1;
    mgmt_write_o = wr;
    mgmt_addr_o = adr;
    mgmt_write_value_o = {val[15:7], 7'h00};
    @(negedge sys_clk_i);
    mgmt_start_o = 1'b0;
    while (!ok && n < 8) begin
      if (mgmt_done_i === 1'b1) begin
        ok = 1'b1;
        rd_data = mgmt_read_value_i;
      end
      else begin
        @(negedge sys_clk_i);
        n++;
      end
    end
    // Keep qualifiers through the edge that samples done high
    @(negedge sys_clk_i);
    mgmt_write_value_o = ~mgmt_write_value_o;
    mgmt_addr_o = ~mgmt_addr_o;
  endtask
  // Read-modify-write; the write drives reserved bits 6:0 as zero
  task automatic rmw(input logic [15:0] set_m);
    xfer(1'b0, 5'h00, 16'h0000);
    xfer(1'b1, 5'h00, rd_data | set_m);
  endtask
endmodule

// ### testbench/phy_control_register_tb_top.sv
`timescale 1ns/1ps
module phy_control_register_tb_top;
  import phy_ctrl_pkg::*;
  // ----
  // Signals
  // ----
  logic sys_clk_i, rstn_i, mgmt_start_i, mgmt_write_i, mgmt_done_o;
  logic an_complete_i, an_duplex_i, tx_start_i, tx_halt_i;
  logic [4:0] mgmt_addr_i;
  logic [15:0] mgmt_write_value_i, mgmt_read_value_o;
  logic phy_reset_o, loopback_select_o, speed_choice_o, autoneg_enable_o;
  logic low_power_select_o, isolate_o, autoneg_restart_o, duplex_o, collision_test_select_o;
  logic [15:0] ctl; // Control outputs laid out as the register
  int err_total = 0;
  int comparisons = 0;
  assign ctl = {phy_reset_o, loopback_select_o, speed_choice_o, autoneg_enable_o,
    low_power_select_o, isolate_o, autoneg_restart_o, duplex_o, collision_test_select_o, 7'h00};
  phy_control_register dut (.sys_clk_i, .rstn_i, .mgmt_start_i, .mgmt_write_i, .mgmt_addr_i,
    .mgmt_write_value_i, .mgmt_read_value_o, .mgmt_done_o, .an_complete_i, .an_duplex_i,
    .tx_start_i, .tx_halt_i, .phy_reset_o, .loopback_select_o, .speed_choice_o,
    .autoneg_enable_o, .low_power_select_o, .isolate_o, .autoneg_restart_o, .duplex_o,
    .collision_test_select_o);
  mgmt_master_model mdl (.sys_clk_i, .mgmt_start_o(mgmt_start_i), .mgmt_write_o(mgmt_write_i),
    .mgmt_addr_o(mgmt_addr_i), .mgmt_write_value_o(mgmt_write_value_i),
    .mgmt_done_i(mgmt_done_o), .mgmt_read_value_i(mgmt_read_value_o));
  // 25 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // ----
  // Helpers
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Transfer plus a check that done arrived
  task automatic tx(input logic wr, input logic [4:0] adr, input logic [15:0] val);
    mdl.xfer(wr, adr, val);
    chk({15'h0000, mdl.ok}, 16'h0001, "no done");
  endtask
  // Pulse one event input; returns once outputs have followed (2 edges)
  task automatic pulse(input int which);
    @(negedge sys_clk_i);
    {an_complete_i, tx_start_i, tx_halt_i} = 3'b100 >> which;
    @(negedge sys_clk_i);
    {an_complete_i, tx_start_i, tx_halt_i} = 3'b000;
    @(negedge sys_clk_i);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end
    else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----
  // Tests
  // ----
  task automatic t_basic;
    tx(1'b0, 5'h00, 16'h0000);
    chk(mdl.rd_data, 16'h3100, "reset read");
    chk(ctl, 16'h3100, "reset ctl");
    tx(1'b1, 5'h00, 16'h4C80);
    chk(ctl, 16'h4C80, "mode bits");
    tx(1'b1, 5'h00, 16'h0000);
    chk(ctl, 16'h0000, "clear ctl");
    mdl.rmw(16'h2100);
    chk(ctl, 16'h2100, "rmw ctl");
    $display("test basic done");
  endtask
  // Unmapped places and the held read result
  task automatic t_unmapped;
    tx(1'b1, 5'h1F, 16'hFF80);
    chk(ctl, 16'h2100, "unmapped write");
    tx(1'b0, 5'h01, 16'h0000);
    chk(mdl.rd_data, 16'h0000, "unmapped read");
    tx(1'b0, 5'h00, 16'h0000);
    tx(1'b1, 5'h00, 16'h3100);
    chk(mgmt_read_value_o, 16'h2100, "read held");
    $display("test unmapped done");
  endtask
  task automatic t_events;
    pulse(1);
    chk(ctl, 16'h3180, "coltest set");
    pulse(2);
    chk(ctl, 16'h3100, "coltest clear");
    tx(1'b1, 5'h00, 16'h1200);
    chk(ctl, 16'h1200, "restart set");
    an_duplex_i = 1'b1;
    pulse(0);
    chk(ctl, 16'h1100, "an result");
    $display("test events done");
  endtask
  // Soft reset holds then restores the default
  task automatic t_soft;
    tx(1'b1, 5'h00, 16'h8000);
    chk(ctl & 16'h8000, 16'h8000, "soft reset on");
    repeat (SOFT_RESET_CYCLES + 4) @(negedge sys_clk_i);
    chk(ctl, 16'h3100, "soft reset end");
    $display("test soft done");
  endtask
  // Main sequence: reset 12 cycles, then tests
  initial begin
    rstn_i = 1'b0;
    {an_complete_i, an_duplex_i, tx_start_i, tx_halt_i} = 4'h0;
    repeat (12) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    t_basic;
    t_unmapped;
    t_events;
    t_soft;
    summarize;
  end
  // Watchdog: the tests need under a hundred cycles
  initial begin
    #(40 * 2000);
    err_total++;
    summarize;
  end
endmodule
